// >>> hdl/tcos_regs.svh
// Register offsets, field positions and reset values of the output stage
`ifndef TCOS_REGS_SVH
`define TCOS_REGS_SVH
`define TCOS_ADDR_CH0CTL   4'h0
`define TCOS_ADDR_CH1CTL   4'h1
`define TCOS_ADDR_CCHP     4'h2
`define TCOS_ADDR_OUTCTL   4'h3
`define TCOS_ADDR_CV0      4'h4
`define TCOS_ADDR_CV1      4'h5
`define TCOS_ADDR_ADD0     4'h6
`define TCOS_ADDR_ADD1     4'h7
`define TCOS_ADDR_SWEVG    4'h8
`define TCOS_ADDR_STAT     4'h9
`define TCOS_F_COMCTL_LSB  0
`define TCOS_F_MPSEL_LSB   4
`define TCOS_F_CCEN        6
`define TCOS_F_CPWM        7
`define TCOS_F_DT_LSB      0
`define TCOS_F_MASTER_OUTPUT_ENABLE        8
`define TCOS_F_ROS         9
`define TCOS_F_IOS         10
`define TCOS_F_BRKEN       11
`define TCOS_F_BRKP        12
`define TCOS_F_MSEL_LSB    13
`define TCOS_F_BREAK_INTERRUPT_ENABLE       15
`define TCOS_F_PEN         0
`define TCOS_F_SEN         1
`define TCOS_F_PPOL        2
`define TCOS_F_SPOL        3
`define TCOS_F_IDP         4
`define TCOS_F_IDS         5
`define TCOS_OUTCTL_BITS   6
`define TCOS_F_SWBRK       0
`define TCOS_RST_CHCTL     8'h00
`define TCOS_RST_CCHP      16'h0000
`define TCOS_RST_OUTCTL    12'h000
`endif

// >>> hdl/tcos_pkg.sv
// Types shared by the output stage files
package tcos_pkg;
  typedef enum logic [3:0] {
    TCOS_CMP_HOLD = 4'h0, TCOS_CMP_SET = 4'h1, TCOS_CMP_CLR = 4'h2, TCOS_CMP_TGL = 4'h3,
    TCOS_CMP_FLO  = 4'h4, TCOS_CMP_FHI = 4'h5, TCOS_CMP_PWM0 = 4'h6, TCOS_CMP_PWM1 = 4'h7
  } tcos_cmp_e;
  typedef enum logic [1:0] {TCOS_MSEL_INDEP = 2'h0, TCOS_MSEL_COMP = 2'h3} tcos_msel_e;
  typedef enum logic [1:0] {TCOS_MP_NORMAL = 2'h0, TCOS_MP_PULSE = 2'h1} tcos_mpsel_e;
endpackage

// >>> hdl/tcos_dead_time.sv
// Dead-time generator for one complementary channel pair
`timescale 1ns/1ns
`default_nettype none
module tcos_dead_time
  import tcos_pkg::*;
#(
  parameter int DT_W = 8
) (
  input  wire logic            core_clk,
  input  wire logic            reset_n,
  input  wire logic            dt_active,
  input  wire logic            prep,
  input  wire logic [DT_W-1:0] dead_time_config,
  output logic                 prim_ok,
  output logic                 sec_ok
);
  logic            prep_reg;
  logic            prep_next;
  logic [DT_W-1:0] cnt_reg;
  logic [DT_W-1:0] cnt_next;
  logic            prim_reg;
  logic            prim_next;
  logic            sec_reg;
  logic            sec_next;

  always_comb begin
    prep_next = prep;
    cnt_next  = cnt_reg;
    prim_next = prim_reg;
    sec_next  = sec_reg;
    if (!dt_active) begin
      cnt_next  = '0;
      prim_next = prep;
      sec_next  = !prep;
    end else if (prep != prep_reg) begin
      // Edge kills the going-inactive side at once and restarts the delay
      cnt_next  = dead_time_config;
      prim_next = 1'b0;
      sec_next  = 1'b0;
      if (dead_time_config == '0) begin
        prim_next = prep;
        sec_next  = !prep;
      end
    end else if (cnt_reg != '0) begin
      // A pulse shorter than the delay never reaches the primary
      cnt_next = cnt_reg - 1'b1;
      if (cnt_reg == {{(DT_W-1){1'b0}}, 1'b1}) begin
        prim_next = prep;
        sec_next  = !prep;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prep_reg <= 1'b0;
      cnt_reg  <= '0;
      prim_reg <= 1'b0;
      sec_reg  <= 1'b0;
    end else begin
      prep_reg <= prep_next;
      cnt_reg  <= cnt_next;
      prim_reg <= prim_next;
      sec_reg  <= sec_next;
    end
  end

  assign prim_ok = prim_reg;
  assign sec_ok  = sec_reg;

  chk_dt_no_overlap : assert property (@(posedge core_clk) disable iff (!reset_n)
    !(prim_reg && sec_reg)) else $error("both dead-time gates open");
endmodule
`default_nettype wire

// >>> hdl/tcos_output_stage.sv
// Compare channel 0/1 output stage: prepare, complementary pairing, dead time, break
`timescale 1ns/1ns
`default_nettype none
`include "tcos_regs.svh"
// Functional notes
// - Select zero passes prepare signal unchanged
// - Select one: one-cycle pulse on up-match
// - Match codes: hold, set, clear, toggle
// - Codes six, seven give PWM modes
// - Codes four, five force inactive, active
// - External trigger clears prepare until update
// - Mode 00 independent, 11 complementary secondary
// - All clear: both outputs low, disconnected
// - Off-state: polarity first, idle after dead
// - Run state: XOR polarity, disabled floats low
// - Run off-state: disabled drives polarity level
// - Dead time only complementary, both enabled
// - Edge clears one side, delays other
// - Short pulse never passes dead time
// - Break enable, polarity, level sensitive
// - Break is OR of all sources
// - Software break acts like hardware break
// - Composite PWM: value offsets pulse start
// - External break from selected pin
// - Break clears master enable, idle levels in complementary mode only
// - Break sets flag, interrupt if enabled
module tcos_output_stage
  import tcos_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int DT_W  = 8,
  parameter int NSRC  = 6
) (
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  input  wire logic [3:0]       reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [31:0]      reg_rdata,
  input  wire logic [CNT_W-1:0] counter_value,
  input  wire logic [CNT_W-1:0] counter_reload,
  input  wire logic             count_down,
  input  wire logic             update_event,
  input  wire logic             filtered_external_trigger,
  input  wire logic             break_input_pin,
  input  wire logic [NSRC-1:0]  break_sources,
  output logic      [1:0]       primary_output,
  output logic      [1:0]       primary_output_en,
  output logic      [1:0]       secondary_output,
  output logic      [1:0]       secondary_output_en,
  output logic                  break_irq
);
  logic [7:0]       chctl_reg [2];
  logic [7:0]       chctl_next [2];
  logic [CNT_W-1:0] cv_reg [2];
  logic [CNT_W-1:0] cv_next [2];
  logic [CNT_W-1:0] add_reg [2];
  logic [CNT_W-1:0] add_next [2];
  logic [15:0]      cchp_reg;
  logic [15:0]      cchp_next;
  logic [11:0]      outctl_reg;
  logic [11:0]      outctl_next;
  logic             flag_reg;
  logic             flag_next;
  logic             swbrk_reg;
  logic             swbrk_next;
  logic [31:0]      rdata_reg;
  logic [31:0]      rdata_next;
  logic             irq_reg;
  logic             irq_next;
  logic [2:0]       pin_sync_reg;
  logic [1:0]       prep_reg;
  logic [1:0]       prep_next;
  logic [1:0]       clr_reg;
  logic [1:0]       clr_next;
  logic [1:0]       off_reg;
  logic [1:0]       off_next;
  logic [1:0]       po_reg;
  logic [1:0]       po_next;
  logic [1:0]       poe_reg;
  logic [1:0]       poe_next;
  logic [1:0]       so_reg;
  logic [1:0]       so_next;
  logic [1:0]       soe_reg;
  logic [1:0]       soe_next;
  logic             pin_level_reg;
  logic             break_evt;
  logic [1:0]       dt_prim;
  logic [1:0]       dt_sec;
  logic [1:0]       dt_active;
  logic [1:0]       off_done;

  wire logic [DT_W-1:0] dt_cfg = cchp_reg[`TCOS_F_DT_LSB +: DT_W];
  wire logic            master_output_enable   = cchp_reg[`TCOS_F_MASTER_OUTPUT_ENABLE] && !break_evt;
  wire logic            run_offstate_select    = cchp_reg[`TCOS_F_ROS];
  wire logic            idle_offstate_select    = cchp_reg[`TCOS_F_IOS];
  wire logic [1:0]      msel   = cchp_reg[`TCOS_F_MSEL_LSB +: 2];

  // Pin path: three stages, a change is taken once stages two and three agree
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_sync_reg  <= 3'h0;
      pin_level_reg <= 1'b0;
    end else begin
      pin_sync_reg <= {pin_sync_reg[1:0], break_input_pin};
      if (pin_sync_reg[2] == pin_sync_reg[1]) begin
        pin_level_reg <= pin_sync_reg[2];
      end
    end
  end

  // Level-sensitive, polarity-selected, ORed with all other sources
  assign break_evt = cchp_reg[`TCOS_F_BRKEN] &&
                     ((pin_level_reg == cchp_reg[`TCOS_F_BRKP]) || (|break_sources) || swbrk_reg);

  // Register file and break bookkeeping
  always_comb begin
    chctl_next  = chctl_reg;
    cv_next     = cv_reg;
    add_next    = add_reg;
    cchp_next   = cchp_reg;
    outctl_next = outctl_reg;
    swbrk_next  = 1'b0;
    rdata_next  = 32'h0000_0000;
    flag_next   = flag_reg;
    if (reg_wr) begin
      unique case (reg_addr)
        `TCOS_ADDR_CH0CTL: chctl_next[0] = reg_wdata[7:0];
        `TCOS_ADDR_CH1CTL: chctl_next[1] = reg_wdata[7:0];
        `TCOS_ADDR_CCHP:   cchp_next = reg_wdata[15:0];
        `TCOS_ADDR_OUTCTL: outctl_next = reg_wdata[11:0];
        `TCOS_ADDR_CV0:    cv_next[0] = reg_wdata[CNT_W-1:0];
        `TCOS_ADDR_CV1:    cv_next[1] = reg_wdata[CNT_W-1:0];
        `TCOS_ADDR_ADD0:   add_next[0] = reg_wdata[CNT_W-1:0];
        `TCOS_ADDR_ADD1:   add_next[1] = reg_wdata[CNT_W-1:0];
        `TCOS_ADDR_SWEVG:  swbrk_next = reg_wdata[`TCOS_F_SWBRK];
        `TCOS_ADDR_STAT: begin
          if (reg_wdata[0]) begin
            flag_next = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `TCOS_ADDR_CH0CTL: rdata_next = {24'h000000, chctl_reg[0]};
        `TCOS_ADDR_CH1CTL: rdata_next = {24'h000000, chctl_reg[1]};
        `TCOS_ADDR_CCHP:   rdata_next = {16'h0000, cchp_reg};
        `TCOS_ADDR_OUTCTL: rdata_next = {20'h00000, outctl_reg};
        `TCOS_ADDR_CV0:    rdata_next = 32'(cv_reg[0]);
        `TCOS_ADDR_CV1:    rdata_next = 32'(cv_reg[1]);
        `TCOS_ADDR_ADD0:   rdata_next = 32'(add_reg[0]);
        `TCOS_ADDR_ADD1:   rdata_next = 32'(add_reg[1]);
        `TCOS_ADDR_STAT:   rdata_next = {26'h0000000, so_reg, po_reg, pin_level_reg, flag_reg};
        default:           rdata_next = 32'h0000_0000;
      endcase
    end
    // Set wins over a clear in the same cycle
    if (break_evt) begin
      flag_next = 1'b1;
      cchp_next[`TCOS_F_MASTER_OUTPUT_ENABLE] = 1'b0;
    end
    irq_next = flag_next && cchp_next[`TCOS_F_BREAK_INTERRUPT_ENABLE];
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      chctl_reg  <= '{`TCOS_RST_CHCTL, `TCOS_RST_CHCTL};
      cv_reg     <= '{default: '0};
      add_reg    <= '{default: '0};
      cchp_reg   <= `TCOS_RST_CCHP;
      outctl_reg <= `TCOS_RST_OUTCTL;
      swbrk_reg  <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      flag_reg   <= 1'b0;
      irq_reg    <= 1'b0;
    end else begin
      chctl_reg  <= chctl_next;
      cv_reg     <= cv_next;
      add_reg    <= add_next;
      cchp_reg   <= cchp_next;
      outctl_reg <= outctl_next;
      swbrk_reg  <= swbrk_next;
      rdata_reg  <= rdata_next;
      flag_reg   <= flag_next;
      irq_reg    <= irq_next;
    end
  end

  // Per channel prepare signal and output control
  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    wire logic [7:0]  ctl  = chctl_reg[ch];
    wire logic [5:0]  oc   = outctl_reg[ch*`TCOS_OUTCTL_BITS +: `TCOS_OUTCTL_BITS];
    wire tcos_cmp_e   mode = tcos_cmp_e'(ctl[`TCOS_F_COMCTL_LSB +: 4]);
    wire logic [1:0]  mps  = ctl[`TCOS_F_MPSEL_LSB +: 2];
    wire logic        hit  = counter_value == cv_reg[ch];
    wire logic        hita = counter_value == add_reg[ch];
    wire logic        pen  = oc[`TCOS_F_PEN];
    wire logic        sen  = oc[`TCOS_F_SEN];
    wire logic        ppol = oc[`TCOS_F_PPOL];
    wire logic        spol = oc[`TCOS_F_SPOL];
    logic             lvl;

    always_comb begin
      lvl = prep_reg[ch];
      unique case (mode)
        TCOS_CMP_HOLD: lvl = prep_reg[ch];
        TCOS_CMP_SET:  lvl = hit ? 1'b1 : prep_reg[ch];
        TCOS_CMP_CLR:  lvl = hit ? 1'b0 : prep_reg[ch];
        TCOS_CMP_TGL:  lvl = hit ? !prep_reg[ch] : prep_reg[ch];
        TCOS_CMP_FLO:  lvl = 1'b0;
        TCOS_CMP_FHI:  lvl = 1'b1;
        TCOS_CMP_PWM0, TCOS_CMP_PWM1: begin
          if (ctl[`TCOS_F_CPWM]) begin
            // Value marks the pulse offset, additional value its other edge
            if (hit) begin
              lvl = (mode == TCOS_CMP_PWM1);
            end else if (hita) begin
              lvl = (mode == TCOS_CMP_PWM0);
            end
          end else begin
            lvl = (counter_value < cv_reg[ch]) ^ (mode == TCOS_CMP_PWM1);
          end
        end
        default: lvl = prep_reg[ch];
      endcase
      clr_next[ch] = clr_reg[ch];
      if (update_event) begin
        clr_next[ch] = 1'b0;
      end
      // Trigger clear holds until the next update event
      if (ctl[`TCOS_F_CCEN] && filtered_external_trigger) begin
        clr_next[ch] = 1'b1;
      end
      if (clr_next[ch]) begin
        lvl = 1'b0;
      end
      if (mps == TCOS_MP_PULSE) begin
        prep_next[ch] = hit && !count_down && !clr_next[ch];
      end else begin
        prep_next[ch] = lvl;
      end
    end

    // Dead time only for complementary pair, both enabled, master on
    assign dt_active[ch] = (msel == TCOS_MSEL_COMP) && pen && sen && master_output_enable;

    tcos_dead_time #(.DT_W(DT_W)) u_dt (
      .core_clk         (core_clk),
      .reset_n          (reset_n),
      .dt_active        (dt_active[ch]),
      .prep             (prep_reg[ch]),
      .dead_time_config (dt_cfg),
      .prim_ok          (dt_prim[ch]),
      .sec_ok           (dt_sec[ch])
    );

    always_comb begin
      off_next[ch] = 1'b0;
      po_next[ch]  = 1'b0;
      poe_next[ch] = 1'b0;
      so_next[ch]  = 1'b0;
      soe_next[ch] = 1'b0;
      if (msel != TCOS_MSEL_COMP) begin
        // Independent secondary keeps its own enable and polarity
        po_next[ch]  = pen && (prep_reg[ch] ^ ppol);
        poe_next[ch] = pen;
        so_next[ch]  = sen && (prep_reg[ch] ^ spol);
        soe_next[ch] = sen;
      end else if (!master_output_enable) begin
        if (!idle_offstate_select && !pen && !sen) begin
          po_next[ch] = 1'b0;
        end else begin
          // Inactive level first, idle level one dead time later
          off_next[ch] = off_reg[ch] || off_done[ch];
          po_next[ch]  = off_reg[ch] ? oc[`TCOS_F_IDP] : ppol;
          so_next[ch]  = off_reg[ch] ? oc[`TCOS_F_IDS] : spol;
          poe_next[ch] = 1'b1;
          soe_next[ch] = 1'b1;
        end
      end else begin
        if (pen) begin
          po_next[ch] = sen ? (dt_prim[ch] ^ ppol) : (prep_reg[ch] ^ ppol);
          poe_next[ch] = 1'b1;
        end else if (run_offstate_select) begin
          po_next[ch]  = ppol;
          poe_next[ch] = 1'b1;
        end
        if (sen) begin
          so_next[ch] = pen ? (dt_sec[ch] ^ spol) : (prep_reg[ch] ^ spol);
          soe_next[ch] = 1'b1;
        end else if (run_offstate_select) begin
          so_next[ch]  = spol;
          soe_next[ch] = 1'b1;
        end
      end
    end

    // Off-state delay counter: counts kernel clock cycles only while a complementary pair is off and not yet idle
    logic [DT_W-1:0] ocnt_reg;
    logic [DT_W-1:0] ocnt_next;
    always_comb begin
      ocnt_next = '0;
      if (msel == TCOS_MSEL_COMP && !master_output_enable && !off_reg[ch] && ocnt_reg != dt_cfg) begin
        ocnt_next = ocnt_reg + 1'b1;
      end
    end
    assign off_done[ch] = (ocnt_reg == dt_cfg) && !master_output_enable;
    always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
        ocnt_reg <= '0;
      end else begin
        ocnt_reg <= ocnt_next;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prep_reg <= 2'h0;
      clr_reg  <= 2'h0;
      off_reg  <= 2'h0;
      po_reg   <= 2'h0;
      poe_reg  <= 2'h0;
      so_reg   <= 2'h0;
      soe_reg  <= 2'h0;
    end else begin
      prep_reg <= prep_next;
      clr_reg  <= clr_next;
      off_reg  <= off_next;
      po_reg   <= po_next;
      poe_reg  <= poe_next;
      so_reg   <= so_next;
      soe_reg  <= soe_next;
    end
  end

  assign reg_rdata           = rdata_reg;
  assign primary_output      = po_reg;
  assign primary_output_en   = poe_reg;
  assign secondary_output    = so_reg;
  assign secondary_output_en = soe_reg;
  assign break_irq           = irq_reg;

  chk_pulse_one_cycle : assert property (@(posedge core_clk) disable iff (!reset_n)
    (chctl_reg[0][`TCOS_F_MPSEL_LSB +: 2] == TCOS_MP_PULSE && $stable(chctl_reg[0]) && prep_reg[0])
      |=> !prep_reg[0] || (counter_value == cv_reg[0]))
    else $error("match pulse longer than one cycle");
  chk_force_levels : assert property (@(posedge core_clk) disable iff (!reset_n)
    (chctl_reg[0][3:0] == TCOS_CMP_FHI && !clr_next[0] && chctl_reg[0][5:4] == 2'h0)
      |=> prep_reg[0])
    else $error("forced active not seen");
  chk_trig_clear : assert property (@(posedge core_clk) disable iff (!reset_n)
    (chctl_reg[0][`TCOS_F_CCEN] && filtered_external_trigger) |=> !prep_reg[0])
    else $error("trigger clear ignored");
  chk_break_flag : assert property (@(posedge core_clk) disable iff (!reset_n)
    break_evt |=> flag_reg && !cchp_reg[`TCOS_F_MASTER_OUTPUT_ENABLE])
    else $error("break did not set flag or clear enable");
  chk_irq_gate : assert property (@(posedge core_clk) disable iff (!reset_n)
    break_irq |-> flag_reg && cchp_reg[`TCOS_F_BREAK_INTERRUPT_ENABLE])
    else $error("interrupt without flag");
  chk_all_off : assert property (@(posedge core_clk) disable iff (!reset_n)
    (msel == TCOS_MSEL_COMP && !master_output_enable && !idle_offstate_select && outctl_reg[1:0] == 2'h0) |=>
      !primary_output_en[0] && !primary_output[0])
    else $error("disabled pair still driven");
  chk_run_off : assert property (@(posedge core_clk) disable iff (!reset_n)
    (msel == TCOS_MSEL_COMP && master_output_enable && run_offstate_select && !outctl_reg[`TCOS_F_PEN]) |=>
      primary_output_en[0] && primary_output[0] == $past(outctl_reg[`TCOS_F_PPOL]))
    else $error("run off-state level wrong");
  chk_comp_exclusive : assert property (@(posedge core_clk) disable iff (!reset_n)
    dt_active[0] |-> !(dt_prim[0] && dt_sec[0]))
    else $error("complementary pair both active");
  cov_break : cover property (@(posedge core_clk) disable iff (!reset_n) break_evt);
  cov_dead : cover property (@(posedge core_clk) disable iff (!reset_n)
    dt_active[0] && $rose(dt_prim[0]));
  cov_idle : cover property (@(posedge core_clk) disable iff (!reset_n) $rose(off_reg[0]));
endmodule
`default_nettype wire

// >>> testbench/tcos_load_model.sv
// Load model: pin levels seen by the power stage behind the channel pins
`timescale 1ns/1ns
`default_nettype none
module tcos_load_model #(
  parameter logic PULL = 1'b0
) (
  input  wire logic [1:0] drv_p,
  input  wire logic [1:0] en_p,
  input  wire logic [1:0] drv_s,
  input  wire logic [1:0] en_s,
  output logic      [1:0] pin_p,
  output logic      [1:0] pin_s
);
  // A released pin falls to the board pull, never to the last driven value
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pin_p[i] = en_p[i] ? drv_p[i] : PULL;
      pin_s[i] = en_s[i] ? drv_s[i] : PULL;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/tb_tcos_output_stage.sv
// Self-checking bench for the compare channel output stage
`timescale 1ns/1ns
`default_nettype none
`include "tcos_regs.svh"
module tb_tcos_output_stage;
  logic        core_clk      = 1'b0;
  logic        reset_n       = 1'b0;
  logic [3:0]  reg_addr      = 4'h0;
  logic [31:0] reg_wdata     = 32'h0;
  logic        reg_wr        = 1'b0;
  logic        reg_rd        = 1'b0;
  logic [15:0] counter_value = 16'h0000;
  logic        count_down    = 1'b0;
  logic        update_event  = 1'b0;
  logic        ext_trig      = 1'b0;
  logic        brk_pin       = 1'b0;
  logic [5:0]  brk_src       = 6'h00;
  logic [31:0] reg_rdata;
  logic [31:0] rv;
  logic [1:0]  prim;
  logic [1:0]  prim_en;
  logic [1:0]  sec;
  logic [1:0]  sec_en;
  logic [1:0]  pin_p;
  logic [1:0]  pin_s;
  logic        break_irq;
  int          failures      = 0;
  int          check_count   = 0;
  int          t1;
  int          t2;

  always #4 core_clk = ~core_clk;

  tcos_output_stage i_tcos_output_stage (
    .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .counter_value(counter_value),
    .counter_reload(16'h0000), .count_down(count_down), .update_event(update_event),
    .filtered_external_trigger(ext_trig), .break_input_pin(brk_pin),
    .break_sources(brk_src), .primary_output(prim), .primary_output_en(prim_en),
    .secondary_output(sec), .secondary_output_en(sec_en), .break_irq(break_irq)
  );

  tcos_load_model i_tcos_load_model (
    .drv_p(prim), .en_p(prim_en), .drv_s(sec), .en_s(sec_en), .pin_p(pin_p), .pin_s(pin_s)
  );

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // One-cycle counter match on channel 0, then count primary high cycles
  task automatic pulse_count(input logic dn, output int n);
    @(posedge core_clk);
    count_down    <= dn;
    counter_value <= 16'h0010;
    @(posedge core_clk);
    counter_value <= 16'h0000;
    count_down    <= 1'b0;
    n = 0;
    repeat (10) begin
      @(posedge core_clk);
      #1;
      n += int'(prim[0] === 1'b1);
    end
  endtask

  task automatic edge_time(input logic [31:0] code, output int tp, output int ts);
    wr(`TCOS_ADDR_CH0CTL, code);
    tp = -1;
    ts = -1;
    for (int c = 0; c < 20; c++) begin
      @(posedge core_clk);
      #1;
      if (tp < 0 && prim[0] === code[0]) tp = c;
      if (ts < 0 && sec[0] === !code[0]) ts = c;
    end
  endtask

  task automatic t_reset;
    rd(`TCOS_ADDR_CCHP, rv);
    chk("cchp reset", 32'h0, rv);
    rd(`TCOS_ADDR_OUTCTL, rv);
    chk("outctl reset", 32'h0, rv);
    rd(4'hF, rv);
    chk("unmapped read", 32'h0, rv);
    chk("enables", 32'h0, {prim_en, sec_en});
    chk("pins", 32'h0, {pin_p, pin_s});
    $display("test reset done");
  endtask

  task automatic t_force;
    wr(`TCOS_ADDR_CCHP, 32'h0000_0100);
    wr(`TCOS_ADDR_OUTCTL, 32'h0000_0141);
    for (int k = 0; k < 2; k++) begin
      wr(`TCOS_ADDR_CH0CTL, k ? 32'h5 : 32'h4);
      wr(`TCOS_ADDR_CH1CTL, k ? 32'h4 : 32'h5);
      wait_cyc(4);
      chk("forced prim", k ? 32'h3 : 32'h0, prim);
      chk("enables", 32'h3, {sec_en, prim_en});
      chk("prim pins", k ? 32'h3 : 32'h0, pin_p);
    end
    $display("test force done");
  endtask

  task automatic t_match;
    logic [3:0] code [6] = '{4'h4, 4'h1, 4'h0, 4'h2, 4'h3, 4'h3};
    logic       expv [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    int         n;
    wr(`TCOS_ADDR_CV0, 32'h10);
    for (int k = 0; k < 6; k++) begin
      wr(`TCOS_ADDR_CH0CTL, {28'h0, code[k]});
      pulse_count(1'b0, n);
      chk("match prim", {31'h0, expv[k]}, {31'h0, prim[0]});
    end
    wr(`TCOS_ADDR_CH0CTL, 32'h11);
    pulse_count(1'b0, n);
    chk("up pulse cycles", 32'h1, 32'(n));
    pulse_count(1'b1, n);
    chk("down pulse cycles", 32'h0, 32'(n));
    $display("test match done");
  endtask

  task automatic t_pwm;
    for (int k = 0; k < 4; k++) begin
      wr(`TCOS_ADDR_CH0CTL, k[1] ? 32'h7 : 32'h6);
      @(posedge core_clk);
      counter_value <= k[0] ? 16'h0020 : 16'h0005;
      wait_cyc(4);
      chk("pwm prim", {31'h0, ~(k[1] ^ k[0])}, {31'h0, prim[0]});
    end
    wr(`TCOS_ADDR_CH0CTL, 32'h46);
    @(posedge core_clk);
    counter_value <= 16'h0005;
    wait_cyc(4);
    chk("pwm before clear", 32'h1, {31'h0, prim[0]});
    @(posedge core_clk);
    ext_trig <= 1'b1;
    @(posedge core_clk);
    ext_trig <= 1'b0;
    wait_cyc(8);
    chk("held clear", 32'h0, {31'h0, prim[0]});
    @(posedge core_clk);
    update_event <= 1'b1;
    @(posedge core_clk);
    update_event  <= 1'b0;
    counter_value <= 16'h0000;
    wait_cyc(4);
    chk("after update", 32'h1, {31'h0, prim[0]});
    $display("test pwm done");
  endtask

  task automatic t_dead;
    int n;
    wr(`TCOS_ADDR_CCHP, 32'h0000_6103);
    wr(`TCOS_ADDR_OUTCTL, 32'h0000_0003);
    wr(`TCOS_ADDR_CH0CTL, 32'h4);
    wait_cyc(8);
    chk("comp pair", 32'h2, {sec[0], prim[0]});
    edge_time(32'h5, t1, t2);
    chk("rise delay", 32'h3, 32'(t1 - t2));
    edge_time(32'h4, t1, t2);
    chk("fall delay", 32'h3, 32'(t2 - t1));
    wr(`TCOS_ADDR_CH0CTL, 32'h11);
    pulse_count(1'b0, n);
    chk("short pulse", 32'h0, 32'(n));
    $display("test dead time done");
  endtask

  task automatic t_break;
    wr(`TCOS_ADDR_OUTCTL, 32'h0000_0013);
    wr(`TCOS_ADDR_CH0CTL, 32'h5);
    for (int k = 0; k < 8; k++) begin
      wr(`TCOS_ADDR_CCHP, 32'h0000_FD02);
      wr(`TCOS_ADDR_STAT, 32'h1);
      wait_cyc(8);
      rd(`TCOS_ADDR_STAT, rv);
      chk("flag idle", 32'h0, {31'h0, rv[0]});
      if (k == 0) wr(`TCOS_ADDR_SWEVG, 32'h1);
      else begin
        @(posedge core_clk);
        if (k == 7) brk_pin <= 1'b1;
        else brk_src[k-1] <= 1'b1;
        repeat (4) @(posedge core_clk);
        brk_pin <= 1'b0;
        brk_src <= 6'h00;
      end
      wait_cyc(10);
      chk("break irq", 32'h1, {31'h0, break_irq});
      chk("idle levels", 32'h1, {sec[0], prim[0]});
      rd(`TCOS_ADDR_CCHP, rv);
      chk("master enable", 32'h0, {31'h0, rv[8]});
      rd(`TCOS_ADDR_STAT, rv);
      chk("break flag", 32'h1, {31'h0, rv[0]});
    end
    wr(`TCOS_ADDR_STAT, 32'h1);
    wait_cyc(2);
    chk("irq cleared", 32'h0, {31'h0, break_irq});
    wr(`TCOS_ADDR_CCHP, 32'h0000_F502);
    @(posedge core_clk);
    brk_src <= 6'h01;
    repeat (4) @(posedge core_clk);
    brk_src <= 6'h00;
    wait_cyc(6);
    rd(`TCOS_ADDR_CCHP, rv);
    chk("no break when off", 32'h1, {31'h0, rv[8]});
    $display("test break done");
  endtask

  // Run off-state, fully released pair and composite offset edges
  task automatic t_modes;
    int n;
    wr(`TCOS_ADDR_CH0CTL, 32'h4);
    wr(`TCOS_ADDR_CCHP, 32'h0000_6300);
    wr(`TCOS_ADDR_OUTCTL, 32'h0000_0006);
    wait_cyc(4);
    chk("run off-state", 32'hD, {sec_en[0], prim_en[0], sec[0], prim[0]});
    wr(`TCOS_ADDR_CCHP, 32'h0000_6000);
    wr(`TCOS_ADDR_OUTCTL, 32'h0000_0000);
    wait_cyc(4);
    chk("pair released", 32'h0, {sec_en[0], prim_en[0], pin_s[0], pin_p[0]});
    wr(`TCOS_ADDR_CCHP, 32'h0000_0100);
    wr(`TCOS_ADDR_OUTCTL, 32'h0000_0001);
    wr(`TCOS_ADDR_ADD0, 32'h20);
    wr(`TCOS_ADDR_CH0CTL, 32'h87);
    pulse_count(1'b0, n);
    chk("offset edge", 32'hA, 32'(n));
    @(posedge core_clk);
    counter_value <= 16'h0020;
    wait_cyc(4);
    chk("added edge", 32'h0, {31'h0, prim[0]});
    $display("test modes done");
  endtask

  task automatic complete_run;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    t_reset;
    t_force;
    t_match;
    t_pwm;
    t_dead;
    t_break;
    t_modes;
    complete_run;
  end

  // Whole run needs a few hundred cycles; far beyond that means a hang
  initial begin
    #200000;
    failures++;
    complete_run;
  end
endmodule
`default_nettype wire
